/* File: rtl/adc_seq_pkg.sv */
// Constants and types shared by the conversion sequencer files
package adc_seq_pkg;
  localparam int NUM_CH = 4;
  localparam int RES_W = 8;
  localparam logic [7:0] CH_SEL_RESET = 8'h00;
  localparam int CH_SEL_LSB = 4;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [1:0] SLOT_FIRST = 2'h0;
  localparam logic [1:0] SLOT_LAST = 2'h3;
  localparam logic [2:0] GROUP_COUNT = 3'h4;

  typedef enum logic [1:0]
  {
    MODE_FIXED_SINGLE = 2'b00,
    MODE_FIXED_CONT = 2'b01,
    MODE_SCAN_SINGLE = 2'b10,
    MODE_SCAN_CONT = 2'b11
  } conv_mode_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_WAIT = 2'b11,
    ST_STORE = 2'b10
  } seq_state_t;

  // Lowest selected channel at or above the given one; flag low if none
  function automatic logic [2:0] next_selected(input logic [3:0] mask, input logic [1:0] from);
    logic [2:0] found;
    found = 3'b000;
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      if (mask[i] && (i >= int'(from)))
      begin
        found = {1'b1, 2'(i)};
      end
    end
    return found;
  endfunction : next_selected
endpackage : adc_seq_pkg

/* File: rtl/adc_result_if.sv */
// Write channel from the sequencer into the result store
`timescale 1ns/1ps
interface adc_result_if;
  logic wr_en;
  logic [1:0] wr_slot;
  logic [7:0] wr_data;
  modport source (output wr_en, output wr_slot, output wr_data);
  modport sink (input wr_en, input wr_slot, input wr_data);
endinterface : adc_result_if

/* File: rtl/adc_result_store.sv */
// Four byte-wide conversion result registers
`timescale 1ns/1ps
module adc_result_store
  import adc_seq_pkg::*;
(
  input wire logic core_clk_in, // Core clock
  input wire logic reset_n_in, // Async reset, active low
  input wire logic clk_en_in, // Freezes state when low
  adc_result_if.sink wr, // Write channel
  output logic [NUM_CH*RES_W-1:0] results_out // Result 3..0 packed
);
  logic [RES_W-1:0] result_reg [NUM_CH];

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        result_reg[i] <= RESULT_RESET;
      end
    end
    else if (clk_en_in && wr.wr_en)
    begin
      result_reg[wr.wr_slot] <= wr.wr_data;
    end
  end

  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      results_out[i*RES_W +: RES_W] = result_reg[i];
    end
  end
endmodule : adc_result_store

/* File: rtl/adc_conversion_sequencer.sv */
// Sequencer for a four-channel converter: fixed or scan, single or continuous
`timescale 1ns/1ps
module adc_conversion_sequencer
  import adc_seq_pkg::*;
(
  input wire logic core_clk_in, // 100 MHz core clock
  input wire logic reset_n_in, // Async reset, active low
  input wire logic clk_en_in, // Freezes all state when low
  input wire logic [7:0] sel_wdata_in, // Channel select write data
  input wire logic sel_we_in, // Channel select write strobe
  input wire logic [1:0] mode_in, // Operating mode
  input wire logic [1:0] fixed_ch_in, // Channel for fixed modes
  input wire logic start_in, // Start pulse
  input wire logic stop_in, // Stop pulse
  input wire logic irq_en_in, // Conversion interrupt enable
  input wire logic done_clr_in, // Clear done flag pulse
  input wire logic conv_done_in, // Core finished one conversion
  input wire logic [7:0] conv_data_in, // Core result, valid with done
  output logic conv_start_out, // Start one conversion pulse
  output logic [1:0] conv_ch_out, // Channel to convert
  output logic [7:0] channel_select_reg_out, // Channel select readback
  output logic [7:0] result_reg_0_out, // Result 0
  output logic [7:0] result_reg_1_out, // Result 1
  output logic [7:0] result_reg_2_out, // Result 2
  output logic [7:0] result_reg_3_out, // Result 3
  output logic busy_out, // Sequence running
  output logic done_flag_out, // Sticky conversion complete
  output logic irq_out // Conversion interrupt level
);
  seq_state_t state, next_state;
  conv_mode_t mode;
  logic [3:0] ch_sel;
  logic [1:0] cur_ch;
  logic [1:0] wr_slot;
  logic [2:0] group_cnt;
  logic stop_pending;
  logic [NUM_CH*RES_W-1:0] results;

  adc_result_if res_if ();

  wire logic is_scan = mode[1];
  wire logic is_cont = mode[0];
  // Readback follows the select register on the write edge itself, so a start one cycle later sees it
  wire logic [3:0] next_ch_sel = sel_we_in ? sel_wdata_in[7:CH_SEL_LSB] : ch_sel;
  wire logic [2:0] first_pick = next_selected(ch_sel, SLOT_FIRST);
  wire logic [2:0] after_pick = (cur_ch == SLOT_LAST) ? 3'b000 : next_selected(ch_sel, 2'(cur_ch + 2'd1));
  wire logic start_ok = start_in && (state == ST_IDLE) && (!mode_in[1] || (ch_sel != 4'h0));
  wire logic store_now = (state == ST_WAIT) && conv_done_in;
  wire logic pass_end = is_scan && !after_pick[2];
  wire logic group_end = !is_scan && is_cont && (group_cnt == GROUP_COUNT - 3'd1);
  wire logic event_now = (state == ST_STORE) && ((!is_scan && !is_cont) || pass_end || group_end);
  wire logic finish_now = (state == ST_STORE) && ((!is_cont && (!is_scan || pass_end)) || stop_pending);
  wire logic [1:0] slot_for_result = (!is_scan && is_cont) ? wr_slot : cur_ch;

  assign res_if.wr_en = store_now;
  assign res_if.wr_slot = slot_for_result;
  assign res_if.wr_data = conv_data_in;

  adc_result_store u_store
  (
    .core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in),
    .clk_en_in(clk_en_in),
    .wr(res_if),
    .results_out(results)
  );

  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
      begin
        if (start_ok)
        begin
          next_state = ST_START;
        end
      end
      ST_START:
      begin
        next_state = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (conv_done_in)
        begin
          next_state = ST_STORE;
        end
      end
      ST_STORE:
      begin
        next_state = finish_now ? ST_IDLE : ST_START;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state <= ST_IDLE;
      ch_sel <= 4'h0;
      mode <= MODE_FIXED_SINGLE;
    end
    else if (clk_en_in)
    begin
      state <= next_state;
      ch_sel <= next_ch_sel;
      if (start_ok)
      begin
        mode <= conv_mode_t'(mode_in);
      end
    end
  end

  // Channel walk: scan visits selected channels in ascending order
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cur_ch <= SLOT_FIRST;
      wr_slot <= SLOT_FIRST;
      group_cnt <= 3'h0;
    end
    else if (clk_en_in)
    begin
      if (start_ok)
      begin
        cur_ch <= mode_in[1] ? first_pick[1:0] : fixed_ch_in;
        wr_slot <= SLOT_FIRST;
        group_cnt <= 3'h0;
      end
      else if (state == ST_STORE)
      begin
        wr_slot <= wr_slot + 2'd1;
        group_cnt <= group_end ? 3'h0 : group_cnt + 3'd1;
        if (is_scan)
        begin
          cur_ch <= after_pick[2] ? after_pick[1:0] : first_pick[1:0];
        end
      end
    end
  end

  // Stop is latched so a pending conversion still lands its result
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      stop_pending <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (state == ST_IDLE)
      begin
        stop_pending <= 1'b0;
      end
      else if (stop_in)
      begin
        stop_pending <= 1'b1;
      end
    end
  end

  // Set wins over a clear arriving in the same cycle
  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      done_flag_out <= 1'b0;
      irq_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      if (event_now)
      begin
        done_flag_out <= 1'b1;
        irq_out <= irq_en_in;
      end
      else if (done_clr_in)
      begin
        done_flag_out <= 1'b0;
        irq_out <= 1'b0;
      end
      else if (!irq_en_in)
      begin
        irq_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      conv_start_out <= 1'b0;
      conv_ch_out <= SLOT_FIRST;
      busy_out <= 1'b0;
      channel_select_reg_out <= CH_SEL_RESET;
      result_reg_0_out <= RESULT_RESET;
      result_reg_1_out <= RESULT_RESET;
      result_reg_2_out <= RESULT_RESET;
      result_reg_3_out <= RESULT_RESET;
    end
    else if (clk_en_in)
    begin
      conv_start_out <= (next_state == ST_START);
      conv_ch_out <= (state == ST_IDLE) ? (mode_in[1] ? first_pick[1:0] : fixed_ch_in)
                     : ((state == ST_STORE && is_scan) ? (after_pick[2] ? after_pick[1:0] : first_pick[1:0]) : cur_ch);
      busy_out <= (next_state != ST_IDLE);
      channel_select_reg_out <= {next_ch_sel, 4'h0};
      result_reg_0_out <= results[0*RES_W +: RES_W];
      result_reg_1_out <= results[1*RES_W +: RES_W];
      result_reg_2_out <= results[2*RES_W +: RES_W];
      result_reg_3_out <= results[3*RES_W +: RES_W];
    end
  end
endmodule : adc_conversion_sequencer

/* File: tb/adc_core_model.sv */
// Behavioural converter core that answers each start after a delay
`timescale 1ns/1ps
module adc_core_model #(parameter int DELAY = 3)
(
  input wire logic clk_in, // Core clock
  input wire logic start_in, // Start one conversion
  input wire logic [1:0] ch_in, // Channel to convert
  output logic done_out = 1'b0, // Result valid pulse
  output logic [7:0] data_out = 8'h00 // Channel on top, count below
);
  int wait_cnt = 0;
  logic [1:0] ch = 2'h0;
  logic [5:0] n = 6'h00;
  // Odd conversions take longer; data is scrambled outside the valid pulse
  always @(negedge clk_in)
  begin
    done_out <= (wait_cnt == 1);
    data_out <= (wait_cnt == 1) ? {ch, n} : ~data_out;
    if (start_in)
    begin
      wait_cnt <= DELAY + (n[0] ? 4 : 0);
      ch <= ch_in;
    end
    else if (wait_cnt != 0)
      wait_cnt <= wait_cnt - 1;
    if (wait_cnt == 1)
      n <= n + 6'h01;
  end
endmodule : adc_core_model

/* File: tb/adc_conversion_sequencer_assertions.sv */
// Port-level checks on the conversion sequencer
`timescale 1ns/1ps
module adc_seq_checker
(
  input wire logic core_clk_in, // Clock
  input wire logic reset_n_in, // Reset
  input wire logic clk_en_in, // Enable
  input wire logic [7:0] sel_wdata_in, // Mask data
  input wire logic sel_we_in, // Mask write
  input wire logic [1:0] mode_in, // Mode
  input wire logic start_in, // Start
  input wire logic stop_in, // Stop
  input wire logic done_clr_in, // Flag clear
  input wire logic conv_done_in, // Core done
  input wire logic conv_start_out, // Core start
  input wire logic [7:0] channel_select_reg_out, // Mask
  input wire logic busy_out, // Busy
  input wire logic done_flag_out, // Flag
  input wire logic irq_out // Interrupt
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire [3:0] mask = channel_select_reg_out[7:4];
  wire idle_start = start_in && clk_en_in && !busy_out;
  sequence stored_s;
    conv_done_in && !stop_in ##1 !stop_in ##1 busy_out;
  endsequence
  start_answer_a: assert property (idle_start && (!mode_in[1] || mask != 4'h0) |=> conv_start_out && busy_out)
    else $error("start not answered");
  empty_scan_a: assert property (idle_start && mode_in[1] && mask == 4'h0 |=> !busy_out && !conv_start_out)
    else $error("empty scan started");
  select_write_a: assert property (sel_we_in && clk_en_in |=> channel_select_reg_out == ($past(sel_wdata_in) & 8'hF0))
    else $error("select readback wrong");
  done_hold_a: assert property (done_flag_out && !done_clr_in && clk_en_in |=> done_flag_out)
    else $error("done flag lost");
  irq_flag_a: assert property (irq_out |-> done_flag_out)
    else $error("interrupt without flag");
  next_start_a: assert property (stored_s |-> conv_start_out)
    else $error("run did not continue");
  flag_timing_a: assert property ($rose(done_flag_out) |-> $past(conv_done_in, 2))
    else $error("flag not tied to a store");
  busy_end_a: assert property ($fell(busy_out) |-> $past(conv_done_in, 2))
    else $error("run ended without a store");
endmodule : adc_seq_checker
bind adc_conversion_sequencer adc_seq_checker chk (.core_clk_in, .reset_n_in, .clk_en_in, .sel_wdata_in,
  .sel_we_in, .mode_in, .start_in, .stop_in, .done_clr_in, .conv_done_in, .conv_start_out,
  .channel_select_reg_out, .busy_out, .done_flag_out, .irq_out);

/* File: tb/adc_conversion_sequencer_bench.sv */
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_bench;
  logic core_clk_in = 1'b0, reset_n_in = 1'b0, clk_en_in = 1'b1, sel_we_in = 1'b0, start_in = 1'b0;
  logic stop_in = 1'b0, irq_en_in = 1'b1, done_clr_in = 1'b0;
  logic [7:0] sel_wdata_in = 8'h00;
  logic [1:0] mode_in = 2'h0, fixed_ch_in = 2'h0, conv_ch_out;
  logic conv_start_out, conv_done_in, busy_out, done_flag_out, irq_out;
  logic [7:0] conv_data_in, channel_select_reg_out, r0, r1, r2, r3, chs = 8'h00;
  int err_count = 0, n_checks = 0, cycles = 0, n_conv = 0, n_base = 0;
  always #5 core_clk_in = ~core_clk_in;
  adc_conversion_sequencer DUT (.core_clk_in, .reset_n_in, .clk_en_in, .sel_wdata_in, .sel_we_in, .mode_in,
    .fixed_ch_in, .start_in, .stop_in, .irq_en_in, .done_clr_in, .conv_done_in, .conv_data_in, .conv_start_out,
    .conv_ch_out, .channel_select_reg_out, .result_reg_0_out(r0), .result_reg_1_out(r1), .result_reg_2_out(r2),
    .result_reg_3_out(r3), .busy_out, .done_flag_out, .irq_out);
  adc_core_model core (.clk_in(core_clk_in), .start_in(conv_start_out), .ch_in(conv_ch_out),
    .done_out(conv_done_in), .data_out(conv_data_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    n_checks++;
    if (seen !== want)
    begin
      err_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic test_done();
    if (err_count == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done
  // Channel history of the last four starts, newest in the low bits
  always @(posedge core_clk_in)
  begin
    cycles <= cycles + 1;
    if (conv_done_in)
      n_conv <= n_conv + 1;
    if (conv_start_out)
      chs <= {chs[5:0], conv_ch_out};
  end
  task automatic run(input logic [1:0] m, input logic [1:0] c, input logic [7:0] sel);
    sel_wdata_in = sel;
    sel_we_in = 1'b1;
    @(negedge core_clk_in);
    sel_we_in = 1'b0;
    mode_in = m;
    fixed_ch_in = c;
    start_in = 1'b1;
    n_base = n_conv;
    @(negedge core_clk_in);
    start_in = 1'b0;
  endtask : run
  task automatic wait_flag();
    for (int i = 0; i < 200 && done_flag_out !== 1'b1; i++)
      @(negedge core_clk_in);
  endtask : wait_flag
  task automatic clr();
    done_clr_in = 1'b1;
    @(negedge core_clk_in);
    done_clr_in = 1'b0;
  endtask : clr
  task automatic halt();
    stop_in = 1'b1;
    @(negedge core_clk_in);
    stop_in = 1'b0;
    for (int i = 0; i < 50 && busy_out !== 1'b0; i++)
      @(negedge core_clk_in);
    check({7'h0, busy_out}, 8'h00);
    clr();
  endtask : halt
  task automatic fixed_single();
    run(2'h0, 2'h2, 8'h00);
    wait_flag();
    check(r2 & 8'hC0, 8'h80);
    check(8'(n_conv - n_base), 8'h01);
    check({7'h0, irq_out}, 8'h01);
    repeat (3) @(negedge core_clk_in);
    check({7'h0, done_flag_out}, 8'h01);
    clr();
    check({7'h0, done_flag_out}, 8'h00);
    // Interrupt masked: the flag still sets, the interrupt line stays low
    irq_en_in = 1'b0;
    run(2'h0, 2'h0, 8'h00);
    wait_flag();
    check({7'h0, irq_out}, 8'h00);
    check(r0, 8'h01);
    irq_en_in = 1'b1;
    clr();
  endtask : fixed_single
  task automatic fixed_cont();
    logic [7:0] first;
    run(2'h1, 2'h1, 8'h00);
    wait_flag();
    first = r0;
    check(8'(n_conv - n_base), 8'h04);
    check(r0 & 8'hC0, 8'h40);
    check(r3, first + 8'h03);
    clr();
    wait_flag();
    check(r0, first + 8'h04);
    halt();
  endtask : fixed_cont
  task automatic scan_single();
    run(2'h2, 2'h0, 8'hA5);
    check(channel_select_reg_out, 8'hA0);
    wait_flag();
    check(8'(n_conv - n_base), 8'h02);
    check(r3 & 8'hC0, 8'hC0);
    check(r1 & 8'hC0, 8'h40);
    clr();
    run(2'h2, 2'h3, 8'h10);
    wait_flag();
    check({r0[7:6], 6'(n_conv - n_base)}, 8'h01);
    clr();
  endtask : scan_single
  task automatic empty_scan();
    run(2'h3, 2'h0, 8'h0F);
    repeat (6) @(negedge core_clk_in);
    check({7'h0, busy_out}, 8'h00);
    check(8'(n_conv - n_base), 8'h00);
  endtask : empty_scan
  task automatic scan_cont();
    run(2'h3, 2'h0, 8'h60);
    wait_flag();
    clr();
    wait_flag();
    check(chs, 8'h66);
    halt();
  endtask : scan_cont
  initial
  begin
    repeat (8) @(negedge core_clk_in);
    check(r0 | r1 | r2 | r3 | channel_select_reg_out, 8'h00);
    reset_n_in = 1'b1;
    // The suite needs well under a thousand cycles; a hang ends in the verdict as a mismatch
    fork
      begin
        fixed_single();
        fixed_cont();
        scan_single();
        empty_scan();
        scan_cont();
      end
      begin
        wait (cycles >= 3000);
        err_count++;
      end
    join_any
    test_done();
  end
endmodule : adc_conversion_sequencer_bench
